// *** hdl/rcp_map.svh ***
// rcp_map.svh - register addresses, field positions, reset values and counts
`ifndef RCP_MAP_SVH
`define RCP_MAP_SVH

`define RCP_STATUS_ADDR   8'h03
`define RCP_ST_BANK_HI    7
`define RCP_ST_BANK_LO    5
`define RCP_ST_WDT_BIT    4
`define RCP_ST_PD_BIT     3
`define RCP_ST_ARITH_HI   2
`define RCP_ST_POR_VAL    8'h18
`define RCP_BANK_CLR      3'h0

`define RCP_CFG_W         6
`define RCP_CFG_RST       6'h3f
`define RCP_CFG_SRC_BIT   5
`define RCP_CFG_EDGE_BIT  4
`define RCP_CFG_ASG_BIT   3
`define RCP_CFG_RATE_HI   2
`define RCP_CFG_UNIMP     2'h0

`define RCP_FL_POR        2'h3
`define RCP_FL_CLR_WAKE   2'h2
`define RCP_FL_WDT_RUN    2'h1
`define RCP_FL_WDT_WAKE   2'h0

`define RCP_RST_HOLD_DEF  4
`define RCP_PRESC_W       8
`define RCP_HOLD_LAST     8'h01
`define RCP_HOLD_STEP     8'h01
`define RCP_HOLD_DONE     8'h00
`define RCP_CLR_IDLE      1'b1
`define RCP_TCK_IDLE      1'b0
`define RCP_RD_IDLE       8'h00

`endif

// *** hdl/rcp_pkg.sv ***
// rcp_pkg.sv - types of the reset cause and prescaler configuration block
package rcp_pkg;

  typedef enum logic [1:0] {
    RCP_RUN      = 2'b00,
    RCP_HOLD_PIN = 2'b01,
    RCP_HOLD_CNT = 2'b10
  } rcp_state_e;

  typedef enum logic [2:0] {
    RCP_CAUSE_POR      = 3'b000,
    RCP_CAUSE_CLR_RUN  = 3'b001,
    RCP_CAUSE_CLR_WAKE = 3'b010,
    RCP_CAUSE_WDT_RUN  = 3'b011,
    RCP_CAUSE_WDT_WAKE = 3'b100
  } rcp_cause_e;

  typedef logic [2:0] rcp_rate_t;

endpackage

// *** hdl/rcp_presc_if.sv ***
// rcp_presc_if.sv - link between the configuration logic and the shared prescaler
`timescale 1ns/10ps
`default_nettype none

interface rcp_presc_if;
  import rcp_pkg::*;
  logic      cnt_event;
  logic      wdt_event;
  logic      assign_wdt;
  rcp_rate_t rate;
  logic      clear;
  logic      cnt_tick;
  logic      wdt_tick;

  modport cfg (
    output cnt_event,
    output wdt_event,
    output assign_wdt,
    output rate,
    output clear,
    input  cnt_tick,
    input  wdt_tick
  );

  modport presc (
    input  cnt_event,
    input  wdt_event,
    input  assign_wdt,
    input  rate,
    input  clear,
    output cnt_tick,
    output wdt_tick
  );
endinterface

`default_nettype wire

// *** hdl/rcp_prescaler.sv ***
// rcp_prescaler.sv - shared power-of-two prescaler for counter or watchdog
`timescale 1ns/10ps
`default_nettype none
`include "rcp_map.svh"

module rcp_prescaler
  import rcp_pkg::*;
#(
  parameter int W = `RCP_PRESC_W
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  rcp_presc_if.presc pif
);

  logic [W-1:0] presc_q;
  logic [W-1:0] presc_d;
  logic [W-1:0] mask;
  logic [3:0]   div;
  logic         ev;
  logic         hit;
  logic         cnt_tick_q;
  logic         cnt_tick_d;
  logic         wdt_tick_q;
  logic         wdt_tick_d;

  // counter divides by 2^(rate+1), watchdog by 2^rate
  assign div = pif.assign_wdt ? {1'b0, pif.rate} : ({1'b0, pif.rate} + 4'h1);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_mask
      assign mask[i] = (4'(i) < div);
    end
  endgenerate

  assign ev  = pif.assign_wdt ? pif.wdt_event : pif.cnt_event;
  assign hit = ((presc_q & mask) == mask);

  always_comb begin
    presc_d    = presc_q;
    cnt_tick_d = 1'b0;
    wdt_tick_d = 1'b0;
    if (pif.clear) begin
      presc_d = '0;
    end else if (ev) begin
      presc_d = hit ? '0 : presc_q + 1'b1;
    end
    if (pif.assign_wdt) begin
      cnt_tick_d = pif.cnt_event;
      wdt_tick_d = pif.wdt_event && hit && !pif.clear;
    end else begin
      cnt_tick_d = pif.cnt_event && hit && !pif.clear;
      wdt_tick_d = pif.wdt_event;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      presc_q    <= '0;
      cnt_tick_q <= 1'b0;
      wdt_tick_q <= 1'b0;
    end else begin
      presc_q    <= presc_d;
      cnt_tick_q <= cnt_tick_d;
      wdt_tick_q <= wdt_tick_d;
    end
  end

  assign pif.cnt_tick = cnt_tick_q;
  assign pif.wdt_tick = wdt_tick_q;

endmodule

`default_nettype wire

// *** hdl/rcp_top.sv ***
// rcp_top.sv - reset cause tracking, status flags and prescaler/counter configuration
`timescale 1ns/10ps
`default_nettype none
`include "rcp_map.svh"

module rcp_top
  import rcp_pkg::*;
#(
  parameter int RST_HOLD = `RCP_RST_HOLD_DEF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       external_clear_pin_n,
  input  wire logic       counter_clock_pin,
  input  wire logic       wdt_expire,
  input  wire logic       wdt_osc_tick,
  input  wire logic       sleep_enter,
  input  wire logic [7:0] file_addr,
  input  wire logic       file_wr_en,
  input  wire logic [7:0] file_wr_data,
  input  wire logic       alu_flags_wr,
  input  wire logic [2:0] alu_flags,
  input  wire logic       cfg_load,
  input  wire logic [7:0] work_reg,
  output logic      [7:0] file_rd_data,
  output logic            device_reset,
  output logic            in_sleep,
  output logic      [2:0] reset_cause,
  output logic            counter_source_select,
  output logic            counter_edge_select,
  output logic            prescaler_assign,
  output logic      [2:0] prescaler_rate,
  output logic            counter_tick,
  output logic            wdt_tick
);

  localparam logic [7:0] HOLD_CNT = 8'(RST_HOLD);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic clr_s1_q;
  logic clr_s1_d;
  logic clr_s2_q;
  logic clr_s2_d;
  logic tck_s1_q;
  logic tck_s1_d;
  logic tck_s2_q;
  logic tck_s2_d;
  logic tck_prev_q;
  logic tck_prev_d;

  // only the second stage reads the first
  always_comb begin
    clr_s1_d   = external_clear_pin_n;
    clr_s2_d   = clr_s1_q;
    tck_s1_d   = counter_clock_pin;
    tck_s2_d   = tck_s1_q;
    tck_prev_d = tck_s2_q;
  end

  // idle pin levels after reset, so no false edge follows it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clr_s1_q   <= `RCP_CLR_IDLE;
      clr_s2_q   <= `RCP_CLR_IDLE;
      tck_s1_q   <= `RCP_TCK_IDLE;
      tck_s2_q   <= `RCP_TCK_IDLE;
      tck_prev_q <= `RCP_TCK_IDLE;
    end else begin
      clr_s1_q   <= clr_s1_d;
      clr_s2_q   <= clr_s2_d;
      tck_s1_q   <= tck_s1_d;
      tck_s2_q   <= tck_s2_d;
      tck_prev_q <= tck_prev_d;
    end
  end

  logic clr_active;
  logic tck_rise;
  logic tck_fall;

  assign clr_active = !clr_s2_q;
  assign tck_rise   = tck_s2_q && !tck_prev_q;
  assign tck_fall   = !tck_s2_q && tck_prev_q;

  // ==========================================================================
  // reset sequencer
  // ==========================================================================
  rcp_state_e state_q;
  rcp_state_e state_d;
  logic [7:0] hold_q;
  logic [7:0] hold_d;
  rcp_cause_e cause_q;
  rcp_cause_e cause_d;
  logic       sleep_q;
  logic       sleep_d;
  logic       enter_rst;
  logic       run_state;
  logic       clr_evt;
  logic       wdt_evt;

  // clear pin wins over a coincident watchdog expiry
  assign run_state = (state_q == RCP_RUN);
  assign clr_evt   = run_state && clr_active;
  assign wdt_evt   = run_state && !clr_active && wdt_expire;

  always_comb begin
    state_d   = state_q;
    hold_d    = hold_q;
    cause_d   = cause_q;
    enter_rst = 1'b0;
    case (state_q)
      RCP_RUN: begin
        if (clr_evt) begin
          enter_rst = 1'b1;
          cause_d   = sleep_q ? RCP_CAUSE_CLR_WAKE : RCP_CAUSE_CLR_RUN;
          state_d   = RCP_HOLD_PIN;
        end else if (wdt_evt) begin
          enter_rst = 1'b1;
          cause_d   = sleep_q ? RCP_CAUSE_WDT_WAKE : RCP_CAUSE_WDT_RUN;
          state_d   = RCP_HOLD_CNT;
          hold_d    = HOLD_CNT;
        end
      end
      RCP_HOLD_PIN: begin
        if (!clr_active) begin
          state_d = RCP_HOLD_CNT;
          hold_d  = HOLD_CNT;
        end
      end
      RCP_HOLD_CNT: begin
        if (clr_active) begin
          state_d = RCP_HOLD_PIN;
        end else if (hold_q <= `RCP_HOLD_LAST) begin
          state_d = RCP_RUN;
          hold_d  = `RCP_HOLD_DONE;
        end else begin
          hold_d = hold_q - `RCP_HOLD_STEP;
        end
      end
      default: begin
        state_d = RCP_HOLD_CNT;
        hold_d  = HOLD_CNT;
      end
    endcase
  end

  logic rst_d;
  logic rst_q;
  assign rst_d = (state_d != RCP_RUN);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= RCP_HOLD_CNT;
      hold_q  <= HOLD_CNT;
      cause_q <= RCP_CAUSE_POR;
      rst_q   <= 1'b1;
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
      cause_q <= cause_d;
      rst_q   <= rst_d;
    end
  end

  // ==========================================================================
  // sleep record
  // ==========================================================================
  // any reset ends sleep, so a wake-up never resumes the old context
  always_comb begin
    sleep_d = sleep_q;
    if (enter_rst) begin
      sleep_d = 1'b0;
    end else if (sleep_enter && run_state) begin
      sleep_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sleep_q <= 1'b0;
    end else begin
      sleep_q <= sleep_d;
    end
  end

  // ==========================================================================
  // status register
  // ==========================================================================
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [1:0] flags_new;
  logic       status_hit;
  logic       status_wr;

  assign status_hit = (file_addr == `RCP_STATUS_ADDR);
  assign status_wr  = file_wr_en && status_hit;

  always_comb begin
    flags_new = {status_q[`RCP_ST_WDT_BIT], status_q[`RCP_ST_PD_BIT]};
    case (cause_d)
      RCP_CAUSE_CLR_RUN:  flags_new = {status_q[`RCP_ST_WDT_BIT], status_q[`RCP_ST_PD_BIT]};
      RCP_CAUSE_CLR_WAKE: flags_new = `RCP_FL_CLR_WAKE;
      RCP_CAUSE_WDT_RUN:  flags_new = `RCP_FL_WDT_RUN;
      RCP_CAUSE_WDT_WAKE: flags_new = `RCP_FL_WDT_WAKE;
      default:            flags_new = `RCP_FL_POR;
    endcase
  end

  always_comb begin
    status_d = status_q;
    if (enter_rst) begin
      // bank select cleared, arithmetic flags kept
      status_d[`RCP_ST_BANK_HI:`RCP_ST_BANK_LO] = `RCP_BANK_CLR;
      status_d[`RCP_ST_WDT_BIT] = flags_new[1];
      status_d[`RCP_ST_PD_BIT]  = flags_new[0];
    end else if (!rst_q) begin
      if (status_wr) begin
        // cause flags are not writable by software
        status_d[`RCP_ST_BANK_HI:`RCP_ST_BANK_LO] =
          file_wr_data[`RCP_ST_BANK_HI:`RCP_ST_BANK_LO];
        status_d[`RCP_ST_ARITH_HI:0] = file_wr_data[`RCP_ST_ARITH_HI:0];
      end
      if (alu_flags_wr) begin
        status_d[`RCP_ST_ARITH_HI:0] = alu_flags;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      status_q <= `RCP_ST_POR_VAL;
    end else begin
      status_q <= status_d;
    end
  end

  // ==========================================================================
  // file read port
  // ==========================================================================
  logic [7:0] rd_d;
  logic [7:0] rd_q;

  // configuration register never reaches the read port
  assign rd_d = status_hit ? status_q : `RCP_RD_IDLE;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_q <= `RCP_RD_IDLE;
    end else begin
      rd_q <= rd_d;
    end
  end

  // ==========================================================================
  // configuration register (write-only)
  // ==========================================================================
  logic [`RCP_CFG_W-1:0] cfg_q;
  logic [`RCP_CFG_W-1:0] cfg_d;
  logic                  cfg_clr_d;
  logic                  cfg_clr_q;

  always_comb begin
    cfg_d     = cfg_q;
    cfg_clr_d = 1'b0;
    if (rst_d) begin
      cfg_d = `RCP_CFG_RST;
    end else if (cfg_load) begin
      // upper two working bits have nowhere to go
      cfg_d     = work_reg[`RCP_CFG_W-1:0];
      cfg_clr_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q     <= `RCP_CFG_RST;
      cfg_clr_q <= 1'b1;
    end else begin
      cfg_q     <= cfg_d;
      cfg_clr_q <= cfg_clr_d | rst_d;
    end
  end

  // ==========================================================================
  // counter event selection and shared prescaler
  // ==========================================================================
  logic pin_event;
  logic cnt_event;

  assign pin_event = cfg_q[`RCP_CFG_EDGE_BIT] ? tck_fall : tck_rise;
  assign cnt_event = cfg_q[`RCP_CFG_SRC_BIT] ? pin_event : 1'b1;

  rcp_presc_if pif ();

  assign pif.cnt_event  = cnt_event && !rst_q;
  assign pif.wdt_event  = wdt_osc_tick;
  assign pif.assign_wdt = cfg_q[`RCP_CFG_ASG_BIT];
  assign pif.rate       = cfg_q[`RCP_CFG_RATE_HI:0];
  assign pif.clear      = cfg_clr_q;

  rcp_prescaler #(
    .W (`RCP_PRESC_W)
  ) u_presc (
    .clk  (clk),
    .nrst (nrst),
    .pif  (pif.presc)
  );

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign file_rd_data          = rd_q;
  assign device_reset          = rst_q;
  assign in_sleep              = sleep_q;
  assign reset_cause           = cause_q;
  assign counter_source_select = cfg_q[`RCP_CFG_SRC_BIT];
  assign counter_edge_select   = cfg_q[`RCP_CFG_EDGE_BIT];
  assign prescaler_assign      = cfg_q[`RCP_CFG_ASG_BIT];
  assign prescaler_rate        = cfg_q[`RCP_CFG_RATE_HI:0];
  assign counter_tick          = pif.cnt_tick;
  assign wdt_tick              = pif.wdt_tick;

endmodule

`default_nettype wire

// *** testbench/rcp_top_checker.sv ***
// rcp_top_checker.sv - concurrent checks on the reset cause block ports
`timescale 1ns/10ps
`default_nettype none

module rcp_top_checker (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       external_clear_pin_n,
  input wire logic       wdt_expire,
  input wire logic       sleep_enter,
  input wire logic [7:0] file_addr,
  input wire logic       cfg_load,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] file_rd_data,
  input wire logic       device_reset,
  input wire logic       in_sleep,
  input wire logic [2:0] reset_cause,
  input wire logic       counter_source_select,
  input wire logic       counter_edge_select,
  input wire logic       prescaler_assign,
  input wire logic [2:0] prescaler_rate,
  input wire logic       counter_tick
);
  wire logic [5:0] cfg = {counter_source_select, counter_edge_select,
                          prescaler_assign, prescaler_rate};
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // watchdog event taken in run state, clear pin quiet
  sequence s_wdt_evt;
    wdt_expire && !device_reset && external_clear_pin_n
      && $past(external_clear_pin_n) && $past(external_clear_pin_n, 2);
  endsequence
  sequence s_hold;
    device_reset [*4] ##1 !device_reset;
  endsequence
  a_por_state: assert property (
    $rose(nrst) |-> device_reset && cfg == 6'h3f && reset_cause == 3'h0 && !in_sleep)
    else $error("power-on state wrong");
  a_cfg_load: assert property (
    cfg_load && !device_reset |=> cfg == $past(work_reg[5:0]))
    else $error("configuration load wrong");
  a_cfg_stable: assert property (
    !cfg_load && !device_reset |=> $stable(cfg) || device_reset)
    else $error("configuration changed without load");
  a_reset_cfg: assert property (
    $rose(device_reset) |=> cfg == 6'h3f)
    else $error("configuration not set by reset");
  a_wdt_cause: assert property (
    s_wdt_evt |=> device_reset && reset_cause == ($past(in_sleep) ? 3'h4 : 3'h3))
    else $error("watchdog cause wrong");
  a_reset_hold: assert property (
    s_wdt_evt |=> s_hold)
    else $error("reset hold length wrong");
  a_sleep_rec: assert property (
    sleep_enter && !device_reset |=> in_sleep)
    else $error("sleep not recorded");
  a_rd_unmapped: assert property (
    file_addr != 8'h03 |=> file_rd_data == 8'h00)
    else $error("read data on unmapped address");
  a_flags_kept: assert property (
    file_addr == 8'h03 && $past(file_addr) == 8'h03 && !device_reset
      |=> file_rd_data[4:3] == $past(file_rd_data[4:3]))
    else $error("cause flags changed outside reset");
  a_cnt_unscaled: assert property (
    (!counter_source_select && prescaler_assign && !device_reset) [*3] |-> counter_tick)
    else $error("counter not unscaled");
endmodule

bind rcp_top rcp_top_checker u_chk (
  .clk(clk), .nrst(nrst), .external_clear_pin_n(external_clear_pin_n),
  .wdt_expire(wdt_expire), .sleep_enter(sleep_enter), .file_addr(file_addr),
  .cfg_load(cfg_load), .work_reg(work_reg), .file_rd_data(file_rd_data),
  .device_reset(device_reset), .in_sleep(in_sleep), .reset_cause(reset_cause),
  .counter_source_select(counter_source_select), .counter_edge_select(counter_edge_select),
  .prescaler_assign(prescaler_assign), .prescaler_rate(prescaler_rate),
  .counter_tick(counter_tick));

`default_nettype wire

// *** testbench/rcp_top_tb_top.sv ***
// rcp_top_tb_top.sv - self-checking bench for the reset cause block
`timescale 1ns/10ps
`default_nettype none

module rcp_top_tb_top;
  logic       clk = 1'b0, nrst = 1'b0, clr_n = 1'b1, cpin = 1'b0, wexp = 1'b0;
  logic       otick = 1'b0, slp = 1'b0, wr = 1'b0, awr = 1'b0, cld = 1'b0;
  logic [7:0] addr = 8'h00, wdat = 8'h00, wreg = 8'h00, rdat;
  logic [2:0] aflg = 3'h0, cause, rate;
  logic       dres, insl, src, edg, asg, ctick, wtick;
  int         fails = 0, comparisons = 0, cycles = 0;

  rcp_top dut (
    .clk(clk), .nrst(nrst), .external_clear_pin_n(clr_n), .counter_clock_pin(cpin),
    .wdt_expire(wexp), .wdt_osc_tick(otick), .sleep_enter(slp), .file_addr(addr),
    .file_wr_en(wr), .file_wr_data(wdat), .alu_flags_wr(awr), .alu_flags(aflg),
    .cfg_load(cld), .work_reg(wreg), .file_rd_data(rdat), .device_reset(dres),
    .in_sleep(insl), .reset_cause(cause), .counter_source_select(src),
    .counter_edge_select(edg), .prescaler_assign(asg), .prescaler_rate(rate),
    .counter_tick(ctick), .wdt_tick(wtick));

  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      close_out();
    end
  end

  task close_out;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wait_run;
    int n;
    n = 0;
    while (dres !== 1'b0 && n < 100) begin
      cyc(1);
      n++;
    end
    chk(8'(dres), 8'h00);
  endtask

  task rd(input logic [7:0] e);
    addr = 8'h03;
    cyc(1);
    chk(rdat, e);
    addr = 8'h00;
  endtask

  task wr_f(input logic [7:0] a, input logic [7:0] d, input logic al);
    addr = a;
    wdat = d;
    wr = 1'b1;
    awr = al;
    aflg = 3'h5;
    cyc(1);
    wr = 1'b0;
    awr = 1'b0;
    addr = 8'h00;
  endtask

  task load(input logic [7:0] w);
    wreg = w;
    cld = 1'b1;
    cyc(1);
    cld = 1'b0;
  endtask

  task per(input logic w, input logic [7:0] e);
    int n;
    logic [7:0] k;
    n = 0;
    k = 8'h00;
    while ((w ? wtick : ctick) !== 1'b1 && n < 600) begin
      cyc(1);
      n++;
    end
    do begin
      cyc(1);
      k++;
    end while ((w ? wtick : ctick) !== 1'b1 && k < 8'hf0);
    chk(k, e);
  endtask

  task pin_cnt(input logic [7:0] e);
    int i;
    logic [7:0] k;
    k = 8'h00;
    for (i = 0; i < 26; i++) begin
      if (i % 4 == 0 && i < 20)
        cpin = ~cpin;
      cyc(1);
      if (ctick === 1'b1)
        k++;
    end
    chk(k, e);
  endtask

  // ==========================================
  // scenarios
  task t_por;
    chk(8'({src, edg, asg, rate}), 8'h3f);
    chk(8'(cause), 8'h00);
    chk(rdat, 8'h00);
    rd(8'h18);
  endtask

  task t_cfg;
    int r;
    load(8'hc5);
    chk(8'({src, edg, asg, rate}), 8'h05);
    for (r = 0; r < 3; r++) begin
      load(8'(r));
      per(1'b0, 8'h02 << r);
    end
    load(8'h0a);
    otick = 1'b1;
    per(1'b1, 8'h04);
    per(1'b0, 8'h01);
    otick = 1'b0;
  endtask

  task t_pin;
    load(8'h28);
    pin_cnt(8'h03);
    load(8'h38);
    pin_cnt(8'h03);
  endtask

  task t_stat;
    wr_f(8'h04, 8'h00, 1'b0);
    cyc(1);
    addr = 8'h03;
    wdat = 8'he0;
    wr = 1'b1;
    awr = 1'b1;
    aflg = 3'h5;
    cyc(1);
    wr = 1'b0;
    awr = 1'b0;
    cyc(1);
    chk(rdat, 8'hfd);
    addr = 8'h00;
  endtask

  task evt(input logic s, input logic p, input logic [7:0] c, input logic [7:0] e);
    load(8'h00);
    if (s) begin
      slp = 1'b1;
      cyc(1);
      slp = 1'b0;
      chk(8'(insl), 8'h01);
    end
    if (p) begin
      clr_n = 1'b0;
      cyc(4);
      clr_n = 1'b1;
    end else begin
      wexp = 1'b1;
      cyc(1);
      wexp = 1'b0;
    end
    wait_run();
    chk(8'({src, edg, asg, rate}), 8'h3f);
    chk(8'(insl), 8'h00);
    chk(8'(cause), c);
    rd(e);
  endtask

  task t_events;
    evt(1'b0, 1'b0, 8'h03, 8'h0d);
    evt(1'b0, 1'b1, 8'h01, 8'h0d);
    evt(1'b1, 1'b0, 8'h04, 8'h05);
    evt(1'b1, 1'b1, 8'h02, 8'h15);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    #1;
    nrst = 1'b1;
    wait_run();
    t_por();
    t_cfg();
    t_pin();
    t_stat();
    t_events();
    close_out();
  end
endmodule

`default_nettype wire
